// ===== rtl/spm_map.vh
// Register map, field positions and reset values of the serial port master.
// Assumes an 8-bit register port with one-cycle strobes and a single clock.
//
// Operation
// - Read flags with tx empty, then write starts.
// - Control one holds eight enable and format bits.
// - Polarity zero gives idle-low serial clock.
// - Phase one puts first edge at transfer start.
// - LSB-first zero shifts most significant bit first.
// - Control two layout; unimplemented and reserved read zero.
// - Fault detect enable zero disables fault detection.
// - Shared output enable zero makes shared pin input.
// - Stop-in-wait zero keeps clocks running in wait.
// - Single-pin mode zero uses separate data pins.
// - Rate register fields; prescale code zero divides one.
// - Rate code zero divides by two.
// - Rate settings apply only as master.
// - Flags bit 7 is receive full; low bits zero.
// - Flags bit 6 is match with compare value.
// - Flags bit 5 is transmit buffer empty.
// - Flags bit 4 reports master mode fault.
// - Compare value is eight bits matched against received.
// - Byte buffer writes transmit, reads receive.
// - Fault cleared by flags read then control one write.
// - Interrupt enables gate their flags onto request.
`ifndef SPM_MAP_VH
`define SPM_MAP_VH

`define SPM_ADDR_W 3
`define SPM_OFF_CTRL1 3'h0
`define SPM_OFF_CTRL2 3'h1
`define SPM_OFF_RATE 3'h2
`define SPM_OFF_FLAGS 3'h3
`define SPM_OFF_CMP 3'h4
`define SPM_OFF_DATA 3'h5

`define SPM_C1_RXIE 7
`define SPM_C1_EN 6
`define SPM_C1_TXIE 5
`define SPM_C1_MASTER_SELECT 4
`define SPM_C1_CLOCK_POLARITY 3
`define SPM_C1_CLOCK_PHASE 2
`define SPM_C1_SELECT_OUTPUT_ENABLE 1
`define SPM_C1_LSBF 0

`define SPM_C2_MIE 7
`define SPM_C2_FDEN 4
`define SPM_C2_BIDOE 3
`define SPM_C2_SWAI 1
`define SPM_C2_SPC 0
`define SPM_C2_MASK 8'h9B

`define SPM_RATE_MASK 8'h7F

`define SPM_S_RXF 7
`define SPM_S_MATCH 6
`define SPM_S_TXE 5
`define SPM_S_FAULT 4

`define SPM_RST_CTRL1 8'h04
`define SPM_RST_CTRL2 8'h00
`define SPM_RST_RATE 8'h00
`define SPM_RST_CMP 8'h00

`define SPM_BITS 8
`define SPM_EDGES 4'hF
`define SPM_TMR_W 20

`endif

// ===== rtl/spm_top.v
// Serial port master: register port, rate generator, shifter and flags.
// Assumes all inputs are synchronous to clk; pin enables are resolved outside.
`include "spm_map.vh"
`default_nettype none

module spm_top
(
	// Clock and reset.
	input wire clk,
	input wire sys_rst,
	// Register port.
	input wire [`SPM_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Processor wait state.
	input wire cpu_wait,
	// Serial clock pin.
	output reg serial_clock_pin_o,
	output reg serial_clock_pin_oe,
	// Master data out pin, shared data pin in single-pin mode.
	input wire mosi_i,
	output reg mosi_o,
	output reg mosi_oe,
	// Master data in pin.
	input wire miso_i,
	// Select pin.
	input wire ss_n_i,
	output reg ss_n_o,
	output reg ss_n_oe,
	// Interrupt request.
	output reg irq_q
);

	// Half period of the serial clock in bus cycles, prescale and rate combined.
	function [`SPM_TMR_W-1:0] half_cycles;
		input [2:0] pre;
		input [3:0] rate;
		begin
			half_cycles = ({17'h00000, pre} + 20'h00001) << rate;
		end
	endfunction

	// Next serial bit taken from the transmit shifter.
	function out_bit;
		input [7:0] sh;
		input lsbf;
		begin
			out_bit = lsbf ? sh[0] : sh[7];
		end
	endfunction

	// Register index decode, shared by the write and the read strobes.
	function addr_hit;
		input [`SPM_ADDR_W-1:0] addr;
		input [`SPM_ADDR_W-1:0] offs;
		begin
			addr_hit = (addr == offs);
		end
	endfunction

	reg [7:0] ctrl1_q;
	reg [7:0] ctrl2_q;
	reg [7:0] rate_q;
	reg [7:0] cmp_q;
	reg [7:0] tx_buf_q;
	reg [7:0] rx_buf_q;
	reg tx_full_q;
	reg rx_full_q;
	reg match_q;
	reg fault_q;
	reg arm_tx_q;
	reg arm_rx_q;
	reg arm_flt_q;
	reg busy_q;
	reg fin_q;
	reg [3:0] edge_q;
	reg [`SPM_TMR_W-1:0] tmr_q;
	reg [7:0] tx_sh_q;
	reg [7:0] rx_sh_q;
	reg sclk_q;
	reg sout_q;
	reg done_q;
	reg smp_q;

	wire en = ctrl1_q[`SPM_C1_EN];
	wire master_select = ctrl1_q[`SPM_C1_MASTER_SELECT];
	wire clock_polarity = ctrl1_q[`SPM_C1_CLOCK_POLARITY];
	wire clock_phase = ctrl1_q[`SPM_C1_CLOCK_PHASE];
	wire select_output_enable = ctrl1_q[`SPM_C1_SELECT_OUTPUT_ENABLE];
	wire lsbf = ctrl1_q[`SPM_C1_LSBF];
	wire fden = ctrl2_q[`SPM_C2_FDEN];
	wire spc = ctrl2_q[`SPM_C2_SPC];
	wire bidoe = ctrl2_q[`SPM_C2_BIDOE];
	wire active = en & master_select;
	wire [`SPM_TMR_W-1:0] half = half_cycles(rate_q[6:4], rate_q[3:0]);
	wire [`SPM_TMR_W-1:0] half_m1 = half - 20'h00001;
	// Frozen only when wait mode stops the clocks; otherwise it keeps running.
	wire freeze = ctrl2_q[`SPM_C2_SWAI] & cpu_wait;
	// In single-pin mode the shared pin is both data in and data out.
	wire sin = spc ? mosi_i : miso_i;
	wire fault_evt = active & fden & ~select_output_enable & ~ss_n_i;

	wire wr_c1 = reg_wr & addr_hit(reg_addr, `SPM_OFF_CTRL1);
	wire wr_c2 = reg_wr & addr_hit(reg_addr, `SPM_OFF_CTRL2);
	wire wr_rate = reg_wr & addr_hit(reg_addr, `SPM_OFF_RATE);
	wire wr_cmp = reg_wr & addr_hit(reg_addr, `SPM_OFF_CMP);
	wire wr_data = reg_wr & addr_hit(reg_addr, `SPM_OFF_DATA);
	wire rd_flags = reg_rd & addr_hit(reg_addr, `SPM_OFF_FLAGS);
	wire rd_data = reg_rd & addr_hit(reg_addr, `SPM_OFF_DATA);
	wire start = active & ~freeze & ~busy_q & tx_full_q & ~fault_q;
	wire load_tx = wr_data & arm_tx_q & ~tx_full_q;
	wire rx_take = done_q & ~rx_full_q;

	wire [7:0] flags = {rx_full_q, match_q, ~tx_full_q, fault_q, 4'h0};

	// Configuration registers. A fault forces slave mode and wins over a write.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl1_q <= `SPM_RST_CTRL1;
			ctrl2_q <= `SPM_RST_CTRL2;
			rate_q <= `SPM_RST_RATE;
			cmp_q <= `SPM_RST_CMP;
		end
		else
		begin
			if (wr_c1)
			begin
				ctrl1_q <= reg_wdata;
			end
			if (fault_evt)
			begin
				ctrl1_q[`SPM_C1_MASTER_SELECT] <= 1'b0;
			end
			if (wr_c2)
			begin
				ctrl2_q <= reg_wdata & `SPM_C2_MASK;
			end
			if (wr_rate)
			begin
				rate_q <= reg_wdata & `SPM_RATE_MASK;
			end
			if (wr_cmp)
			begin
				cmp_q <= reg_wdata;
			end
		end
	end

	// Transmit buffer and the read-then-access clearing sequences.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_buf_q <= 8'h00;
			tx_full_q <= 1'b0;
			arm_tx_q <= 1'b0;
			arm_rx_q <= 1'b0;
			arm_flt_q <= 1'b0;
		end
		else
		begin
			if (load_tx)
			begin
				tx_buf_q <= reg_wdata;
				tx_full_q <= 1'b1;
			end
			else if (start)
			begin
				tx_full_q <= 1'b0;
			end
			// A flags read arms each clearing sequence whose flag is set. Other accesses in between
			// leave it armed, which keeps the logic small; the matching access of
			// the sequence, or a fresh flags read, is what disarms it.
			if (rd_flags)
			begin
				arm_tx_q <= ~tx_full_q;
			end
			else if (wr_data)
			begin
				arm_tx_q <= 1'b0;
			end
			if (rd_flags)
			begin
				arm_rx_q <= rx_full_q;
			end
			else if (rd_data)
			begin
				arm_rx_q <= 1'b0;
			end
			if (rd_flags)
			begin
				arm_flt_q <= fault_q;
			end
			else if (wr_c1)
			begin
				arm_flt_q <= 1'b0;
			end
		end
	end

	// Receive buffer, match and fault flags; a setting event beats a clear.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_buf_q <= 8'h00;
			rx_full_q <= 1'b0;
			match_q <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			// An unserviced receive buffer drops later bytes.
			if (rx_take)
			begin
				rx_buf_q <= rx_sh_q;
				rx_full_q <= 1'b1;
				match_q <= (rx_sh_q == cmp_q);
			end
			else if (rd_data & arm_rx_q)
			begin
				rx_full_q <= 1'b0;
				match_q <= 1'b0;
			end
			if (fault_evt)
			begin
				fault_q <= 1'b1;
			end
			else if (wr_c1 & arm_flt_q)
			begin
				fault_q <= 1'b0;
			end
		end
	end

	// Shift engine. Edges are numbered 0 to 15; even ones are leading edges.
	// With phase one the first edge comes at once, otherwise half a period later.
	// The pins trail the internal state by one cycle. Input data are therefore
	// taken one cycle after the internal sampling edge, when the pin has shown
	// that edge to the peer; this costs a cycle of latency but keeps the sample
	// half a serial period after the peer has driven the line.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busy_q <= 1'b0;
			fin_q <= 1'b0;
			done_q <= 1'b0;
			edge_q <= 4'h0;
			tmr_q <= {`SPM_TMR_W{1'b0}};
			tx_sh_q <= 8'h00;
			rx_sh_q <= 8'h00;
			sclk_q <= 1'b0;
			sout_q <= 1'b0;
			smp_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			smp_q <= 1'b0;
			if (smp_q)
				rx_sh_q <= lsbf ? {sin, rx_sh_q[7:1]} : {rx_sh_q[6:0], sin};
			if (~active | fault_q)
			begin
				busy_q <= 1'b0;
				fin_q <= 1'b0;
				sclk_q <= clock_polarity;
			end
			else if (freeze)
			begin
				busy_q <= busy_q;
			end
			else if (start)
			begin
				busy_q <= 1'b1;
				fin_q <= 1'b0;
				edge_q <= 4'h0;
				sclk_q <= clock_polarity;
				if (clock_phase)
				begin
					tx_sh_q <= tx_buf_q;
					tmr_q <= {`SPM_TMR_W{1'b0}};
				end
				else
				begin
					sout_q <= out_bit(tx_buf_q, lsbf);
					tx_sh_q <= lsbf ? {1'b0, tx_buf_q[7:1]} : {tx_buf_q[6:0], 1'b0};
					tmr_q <= half_m1;
				end
			end
			else if (busy_q)
			begin
				if (tmr_q != {`SPM_TMR_W{1'b0}})
					tmr_q <= tmr_q - 20'h00001;
				else
				begin
					tmr_q <= half_m1;
					if (fin_q)
					begin
						busy_q <= 1'b0;
						fin_q <= 1'b0;
						done_q <= 1'b1;
					end
					else
					begin
						sclk_q <= ~sclk_q;
						if (edge_q[0] ^ clock_phase)
						begin
							sout_q <= out_bit(tx_sh_q, lsbf);
							tx_sh_q <= lsbf ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
						end
						else
							smp_q <= 1'b1;
						if (edge_q == `SPM_EDGES)
							fin_q <= 1'b1;
						edge_q <= edge_q + 4'h1;
					end
				end
			end
		end
	end

	// Pins, read data and interrupt request, all registered.
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_rdata <= 8'h00;
			serial_clock_pin_o <= 1'b0;
			serial_clock_pin_oe <= 1'b0;
			mosi_o <= 1'b0;
			mosi_oe <= 1'b0;
			ss_n_o <= 1'b1;
			ss_n_oe <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			serial_clock_pin_o <= sclk_q;
			serial_clock_pin_oe <= active & ~fault_q;
			mosi_o <= sout_q;
			mosi_oe <= active & ~fault_q & (~spc | bidoe);
			ss_n_o <= ~busy_q;
			ss_n_oe <= active & ~fault_q & fden & select_output_enable;
			// The request is a plain level: software acknowledges it only by
			// clearing the flag behind it, by dropping the matching enable, or by clearing the module enable en.
			irq_q <= en & ((ctrl1_q[`SPM_C1_RXIE] & (rx_full_q | fault_q))
				| (ctrl1_q[`SPM_C1_TXIE] & ~tx_full_q)
				| (ctrl2_q[`SPM_C2_MIE] & match_q));
			reg_rdata <= 8'h00;
			if (reg_rd)
			begin
				case (reg_addr)
					`SPM_OFF_CTRL1: reg_rdata <= ctrl1_q;
					`SPM_OFF_CTRL2: reg_rdata <= ctrl2_q;
					`SPM_OFF_RATE: reg_rdata <= rate_q;
					`SPM_OFF_FLAGS: reg_rdata <= flags;
					`SPM_OFF_CMP: reg_rdata <= cmp_q;
					`SPM_OFF_DATA: reg_rdata <= rx_buf_q;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule // spm_top

`default_nettype wire

// ===== rtl/spm_unused_guard.v
`default_nettype none
`default_nettype wire

// ===== tb/spm_peer.sv
// Serial peer model: shifts a byte out on the in line, captures the out line.
// Assumes a clock that idles low and an active-low select from the master.
`default_nettype none
module spm_peer (
	// Link pins.
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	// Set up and result.
	input wire logic clock_phase,
	input wire logic [7:0] tx,
	output logic [7:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	initial miso = 1'h0;
	// Phase zero needs the first bit on the line before any clock edge.
	always @(negedge ss_n)
	begin
		sh = tx;
		if (!clock_phase)
			miso <= tx[7];
	end
	always @(posedge sclk)
		if (!ss_n)
			if (clock_phase)
				miso <= sh[7];
			else
				rx <= {rx[6:0], mosi};
	always @(negedge sclk)
		if (!ss_n)
		begin
			if (clock_phase)
				rx <= {rx[6:0], mosi};
			else
				miso <= sh[6];
			sh <= {sh[6:0], 1'h0};
		end
	// A released line shows the opposite of its last bit, never a stale one.
	always @(posedge ss_n)
		miso <= ~miso;
endmodule // spm_peer
`default_nettype wire

// ===== tb/spm_top_chk.sv
// Port checker for the serial port master.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module spm_top_chk (
	// Clock and reset.
	input wire clk,
	input wire sys_rst,
	// Register port.
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// Pins.
	input wire serial_clock_pin_o,
	input wire mosi_oe,
	input wire ss_n_o,
	input wire irq_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [7:0] c1_q, c2_q, rt_q;
	logic [4:0] tg_q;
	// Shadow copies; the fault path only touches the master bit, unused here.
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			c1_q <= 8'h04;
			c2_q <= 8'h00;
			rt_q <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == 3'h0)
				c1_q <= reg_wdata;
			if (reg_addr == 3'h1)
				c2_q <= reg_wdata;
			if (reg_addr == 3'h2)
				rt_q <= reg_wdata;
		end
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst || ss_n_o)
			tg_q <= 5'h00;
		else if ($changed(serial_clock_pin_o))
			tg_q <= tg_q + 5'h01;
	chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside answer");
	chk_unmapped_zero: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_ctrl2_mask: assert property (reg_rd && reg_addr == 3'h1 |=> !(reg_rdata & 8'h64))
		else $error("control two spare bits set");
	chk_rate_top: assert property (reg_rd && reg_addr == 3'h2 |=> !reg_rdata[7])
		else $error("rate bit 7 set");
	chk_flags_low: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata[3:0] == 4'h0)
		else $error("flags low bits set");
	chk_idle_clock: assert property (ss_n_o [*2] |-> serial_clock_pin_o == c1_q[3])
		else $error("serial clock not at idle level");
	chk_edge_count: assert property ($rose(ss_n_o) |-> tg_q == 5'h10)
		else $error("frame edge count wrong");
	chk_fast_clock: assert property (
		!ss_n_o && rt_q == 8'h00 && tg_q > 5'h00 && tg_q < 5'h10
		|-> $changed(serial_clock_pin_o))
		else $error("serial clock not half bus rate");
	chk_single_pin: assert property ((c2_q[0] && !c2_q[3]) [*3] |-> !mosi_oe)
		else $error("shared pin driven as input");
	chk_irq_masked: assert property ((!c1_q[7] && !c1_q[5] && !c2_q[7]) [*3] |-> !irq_q)
		else $error("request with all enables off");
	cover property ($rose(ss_n_o));
	cover property (reg_rd && reg_addr > 3'h5);
	cover property ($rose(irq_q));
endmodule // spm_top_chk
`default_nettype wire

// ===== tb/tb_top.sv
// Bench for the serial port master: register tasks, byte model and peer.
// Assumes the peer answers on the select and clock pins of the design.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, sys_rst = 1'h1, wr = 1'h0, rd = 1'h0, wt = 1'h0, ssi_n = 1'h1;
	logic [2:0] ad = 3'h0;
	logic [7:0] wd = 8'h00, ptx = 8'h00, prx, rv;
	logic [31:0] lf = 32'h6170;
	logic [7:0] mdl [8] = '{8'h04, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] msk [8] = '{8'hFF, 8'h9B, 8'h7F, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
	int errors = 0, compares = 0, frames = 0, k;
	wire [7:0] rdata;
	wire sck, mo, mo_oe, sel_n, irq, miso;
	wire mosi_w = mo_oe ? mo : 1'h1;
	spm_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .cpu_wait(wt), .serial_clock_pin_o(sck),
		.serial_clock_pin_oe(), .mosi_i(mosi_w), .mosi_o(mo), .mosi_oe(mo_oe), .miso_i(miso),
		.ss_n_i(ssi_n), .ss_n_o(sel_n), .ss_n_oe(), .irq_q(irq));
	spm_peer peer (.sclk(sck), .ss_n(sel_n), .mosi(mosi_w), .miso(miso), .clock_phase(mdl[0][2]),
		.tx(ptx), .rx(prx));
	initial forever #5 clk = ~clk;
	always @(negedge sel_n) frames++;
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic test_done();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1'h1;
		if (msk[a] != 8'h00)
			mdl[a] = d & msk[a];
		@(posedge clk);
		wr <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just after it.
	task automatic rd_chk(input logic [2:0] a);
		@(posedge clk);
		ad <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 rv = rdata;
		cmp("register", mdl[a], rv);
	endtask
	// Least-significant-first frames arrive bit-reversed against the peer's order.
	task automatic xfer(input logic [7:0] c1, input logic [7:0] rt, input logic eq);
		logic [7:0] ex, ep;
		lf = nx(lf);
		ptx = lf[7:0];
		ex = ptx;
		ep = lf[15:8];
		if (c1[0])
		begin
			ex = {<<{ptx}};
			ep = {<<{lf[15:8]}};
		end
		wr_reg(3'h0, c1);
		wr_reg(3'h1, 8'h00);
		wr_reg(3'h2, rt);
		wr_reg(3'h4, eq ? ex : ~ex);
		rd_chk(3'h3);
		k = frames;
		wr_reg(3'h5, lf[15:8]);
		for (int i = 0; i < 600 && (frames == k || sel_n !== 1'h1); i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		cmp("frames", 8'h01, 8'(frames - k));
		cmp("peer rx", ep, prx);
		mdl[5] = ex;
		mdl[3] = eq ? 8'hE0 : 8'hA0;
		rd_chk(3'h3);
		rd_chk(3'h5);
		mdl[3] = 8'h20;
	endtask
	initial
	begin
		#200000;
		errors++;
		test_done();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'h0;
		for (int a = 0; a < 8; a++)
			if (a != 3)
				rd_chk(3'(a));
		wr_reg(3'h1, 8'hFF);
		wr_reg(3'h2, 8'hFF);
		rd_chk(3'h1);
		rd_chk(3'h2);
		wr_reg(3'h0, 8'h54);
		wr_reg(3'h1, 8'h00);
		wr_reg(3'h2, 8'h00);
		k = frames;
		wr_reg(3'h5, 8'hA5);
		repeat (40) @(posedge clk);
		cmp("refused", 8'h00, 8'(frames - k));
		wt <= 1'h1;
		xfer(8'h54, 8'h00, 1'h0);
		wt <= 1'h0;
		xfer(8'h50, 8'h11, 1'h1);
		xfer(8'h55, 8'h00, 1'h1);
		wr_reg(3'h1, 8'h01);
		repeat (4) @(posedge clk);
		cmp("mosi_oe", 8'h00, {7'h00, mo_oe});
		wr_reg(3'h1, 8'h00);
		ssi_n <= 1'h0;
		repeat (4) @(posedge clk);
		rd_chk(3'h3);
		wr_reg(3'h1, 8'h10);
		repeat (4) @(posedge clk);
		mdl[3] = 8'h30;
		mdl[0] = mdl[0] & 8'hEF;
		rd_chk(3'h3);
		rd_chk(3'h0);
		ssi_n <= 1'h1;
		repeat (4) @(posedge clk);
		wr_reg(3'h0, 8'h54);
		mdl[3] = 8'h20;
		rd_chk(3'h3);
		wr_reg(3'h0, 8'h74);
		repeat (3) @(posedge clk);
		cmp("irq", 8'h01, {7'h00, irq});
		wr_reg(3'h0, 8'h54);
		repeat (3) @(posedge clk);
		cmp("irq", 8'h00, {7'h00, irq});
		test_done();
	end
endmodule // tb_top
bind spm_top spm_top_chk chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.serial_clock_pin_o(serial_clock_pin_o), .mosi_oe(mosi_oe), .ss_n_o(ss_n_o),
	.irq_q(irq_q));
`default_nettype wire
